// ===== verilog/mie_pkg.sv
package mie_pkg;

  // ----------------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------------
  localparam int unsigned INSTR_W      = 14;
  localparam logic [13:0] OPC_LIT_ACC  = 14'h3000;
  localparam logic [13:0] MSK_LIT_ACC  = 14'h3F00;
  localparam logic [13:0] OPC_BANK     = 14'h0020;
  localparam logic [13:0] MSK_BANK     = 14'h3FE0;
  localparam logic [13:0] OPC_PAGE     = 14'h3180;
  localparam logic [13:0] MSK_PAGE     = 14'h3F80;
  localparam logic [13:0] OPC_STORE    = 14'h0080;
  localparam logic [13:0] MSK_STORE    = 14'h3F80;
  localparam logic [13:0] OPC_IND_MM   = 14'h0010;
  localparam logic [13:0] MSK_IND_MM   = 14'h3FF8;
  localparam logic [13:0] OPC_IND_OFS  = 14'h3F00;
  localparam logic [13:0] MSK_IND_OFS  = 14'h3F80;

  // Field positions inside the instruction word.
  localparam int unsigned MM_LSB       = 0;
  localparam int unsigned MM_SEL_BIT   = 2;
  localparam int unsigned OFS_LSB      = 0;
  localparam int unsigned OFS_W        = 6;
  localparam int unsigned OFS_SEL_BIT  = 6;
  localparam int unsigned BANK_W       = 5;
  localparam int unsigned PAGE_W       = 7;
  localparam int unsigned FILE_W       = 7;

  // Auto update mode field codes.
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // File addresses that stand for the two indirect data ports.
  localparam logic [6:0] IND0_FILE     = 7'h00;
  localparam logic [6:0] IND1_FILE     = 7'h01;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_ACC       = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_BANK      = 8'h08;
  localparam logic [7:0] REG_PAGE      = 8'h0C;
  localparam logic [7:0] REG_PTR0      = 8'h10;
  localparam logic [7:0] REG_PTR1      = 8'h14;
  localparam logic [7:0] REG_COUNT     = 8'h18;

  localparam logic [7:0]  RST_ACC      = 8'h00;
  localparam logic [4:0]  RST_BANK     = 5'h00;
  localparam logic [6:0]  RST_PAGE     = 7'h00;
  localparam logic [15:0] RST_PTR      = 16'h0000;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// ===== verilog/mie_core.sv
`timescale 1ns/10ps
// What this block does
// - Indirect load copies the addressed byte to the accumulator, sets zero.
// - Mode field: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Pointer ends one up or down; offset form leaves it unchanged.
// - Select bit picks pointer; pre modes step before, post modes after.
// - Indirect data port access goes to the address held in its pointer.
// - Pointers are 16 bits and wrap at both ends of their range.
// - Pointer update leaves flags alone; only loaded data sets zero flag.
// - Load bank literal writes bank select register, flags unchanged.
// - Page literal writes seven-bit program counter high latch; flags kept.
// - Literal load puts eight-bit value in accumulator, one cycle, no flags.
// - Store copies accumulator to the seven-bit addressed file register.
module mie_core
  import mie_pkg::*;
#(
  parameter int unsigned DATA_AW = 8
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        instr_valid,
  output logic                             instr_ready,
  input  wire logic [mie_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import mie_pkg::*;

  // ----------------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------------
  logic [7:0]  acc_q,  acc_d;
  logic        zero_q, zero_d;
  logic [4:0]  bank_q, bank_d;
  logic [6:0]  page_q, page_d;
  logic [15:0] ptr0_q, ptr0_d;
  logic [15:0] ptr1_q, ptr1_d;
  logic [31:0] count_q;
  logic [7:0]  mem_q [2**DATA_AW];

  // ----------------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------------
  logic        awv_q, wv_q, bvalid_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire exec      = instr_valid & instr_ready;
  wire is_lit    = (instr_word & MSK_LIT_ACC) == OPC_LIT_ACC;
  wire is_bank   = (instr_word & MSK_BANK) == OPC_BANK;
  wire is_page   = (instr_word & MSK_PAGE) == OPC_PAGE;
  wire is_store  = (instr_word & MSK_STORE) == OPC_STORE;
  wire is_mm     = (instr_word & MSK_IND_MM) == OPC_IND_MM;
  wire is_ofs    = (instr_word & MSK_IND_OFS) == OPC_IND_OFS;
  wire is_ld     = is_mm | is_ofs;

  wire [1:0] mode     = instr_word[MM_LSB +: 2];
  wire       mode_dec = mode[0];
  wire       mode_post = mode[1];
  wire       sel      = is_ofs ? instr_word[OFS_SEL_BIT]
                               : instr_word[MM_SEL_BIT];
  wire [5:0] ofs      = instr_word[OFS_LSB +: OFS_W];
  // An offset of zero is simply the all-zero field.
  wire [15:0] ofs_ext = {{10{ofs[5]}}, ofs};

  wire [15:0] ptr_cur  = sel ? ptr1_q : ptr0_q;
  // Plain 16-bit arithmetic wraps both ways without extra logic.
  wire [15:0] ptr_step = mode_dec ? ptr_cur - 16'h0001
                                  : ptr_cur + 16'h0001;
  wire [15:0] ptr_new  = is_ofs ? ptr_cur : ptr_step;
  wire [15:0] ld_ea    = is_ofs ? ptr_cur + ofs_ext
                       : (mode_post ? ptr_cur : ptr_step);
  wire [7:0]  ld_data  = mem_q[ld_ea[DATA_AW-1:0]];

  wire [6:0]  st_f     = instr_word[FILE_W-1:0];
  wire [15:0] st_ea    = (st_f == IND0_FILE) ? ptr0_q
                       : (st_f == IND1_FILE) ? ptr1_q
                       : {9'h000, st_f};

  // ----------------------------------------------------------------------
  // Bus write path
  // ----------------------------------------------------------------------
  wire wr_fire  = awv_q & wv_q & ~bvalid_q;
  wire wr_hit   = (awaddr_q == REG_ACC) | (awaddr_q == REG_STATUS)
                | (awaddr_q == REG_BANK) | (awaddr_q == REG_PAGE)
                | (awaddr_q == REG_PTR0) | (awaddr_q == REG_PTR1)
                | (awaddr_q == REG_COUNT);
  wire wr_b0    = wr_fire & wstrb_q[0];
  wire wr_b1    = wr_fire & wstrb_q[1];
  wire [15:0] ptr0_bus = {wr_b1 ? wdata_q[15:8] : ptr0_q[15:8],
                          wr_b0 ? wdata_q[7:0] : ptr0_q[7:0]};
  wire [15:0] ptr1_bus = {wr_b1 ? wdata_q[15:8] : ptr1_q[15:8],
                          wr_b0 ? wdata_q[7:0] : ptr1_q[7:0]};
  wire bus_ptr0 = (wr_b0 | wr_b1) & (awaddr_q == REG_PTR0);
  wire bus_ptr1 = (wr_b0 | wr_b1) & (awaddr_q == REG_PTR1);

  // A bus write and an instruction never share a cycle, so software never
  // races the core on the same register.
  assign instr_ready   = ~wr_fire;
  assign s_axi_awready = ~awv_q & ~bvalid_q;
  assign s_axi_wready  = ~wv_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  assign acc_d  = (wr_b0 & (awaddr_q == REG_ACC)) ? wdata_q[7:0]
                : (exec & is_lit) ? instr_word[7:0]
                : (exec & is_ld) ? ld_data
                : acc_q;
  assign zero_d = (exec & is_ld) ? (ld_data == 8'h00) : zero_q;
  assign bank_d = (wr_b0 & (awaddr_q == REG_BANK)) ? wdata_q[4:0]
                : (exec & is_bank) ? instr_word[BANK_W-1:0]
                : bank_q;
  assign page_d = (wr_b0 & (awaddr_q == REG_PAGE)) ? wdata_q[6:0]
                : (exec & is_page) ? instr_word[PAGE_W-1:0]
                : page_q;
  assign ptr0_d = bus_ptr0 ? ptr0_bus
                : (exec & is_ld & ~sel) ? ptr_new : ptr0_q;
  assign ptr1_d = bus_ptr1 ? ptr1_bus
                : (exec & is_ld & sel) ? ptr_new : ptr1_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q   <= RST_ACC;
      zero_q  <= 1'b0;
      bank_q  <= RST_BANK;
      page_q  <= RST_PAGE;
      ptr0_q  <= RST_PTR;
      ptr1_q  <= RST_PTR;
      count_q <= 32'h0000_0000;
    end else begin
      acc_q   <= acc_d;
      zero_q  <= zero_d;
      bank_q  <= bank_d;
      page_q  <= page_d;
      ptr0_q  <= ptr0_d;
      ptr1_q  <= ptr1_d;
      count_q <= count_q + {31'h0000_0000, exec};
    end
  end

  // File registers hold no reset; software must not rely on their contents.
  always_ff @(posedge aclk) begin
    if (exec & is_store) begin
      mem_q[st_ea[DATA_AW-1:0]] <= acc_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_q    <= 1'b0;
      wv_q     <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awv_q    <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        awv_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wv_q    <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        wv_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus read path
  // ----------------------------------------------------------------------
  wire [31:0] rd_mux =
      (s_axi_araddr == REG_ACC)    ? {24'h00_0000, acc_q}
    : (s_axi_araddr == REG_STATUS) ? {31'h0000_0000, zero_q}
    : (s_axi_araddr == REG_BANK)   ? {27'h000_0000, bank_q}
    : (s_axi_araddr == REG_PAGE)   ? {25'h000_0000, page_q}
    : (s_axi_araddr == REG_PTR0)   ? {16'h0000, ptr0_q}
    : (s_axi_araddr == REG_PTR1)   ? {16'h0000, ptr1_q}
    : (s_axi_araddr == REG_COUNT)  ? count_q
    : 32'h0000_0000;
  wire rd_hit = (s_axi_araddr[7:2] <= REG_COUNT[7:2])
              & (s_axi_araddr[1:0] == 2'h0);

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_LIT_ACC: assert property (
    exec & is_lit |=> acc_q == $past(instr_word[7:0]) && $stable(zero_q))
    else $error("literal not loaded into accumulator");
  AST_BANK: assert property (
    exec & is_bank |=> bank_q == $past(instr_word[4:0]) && $stable(zero_q))
    else $error("bank literal not loaded");
  AST_PAGE: assert property (
    exec & is_page |=> page_q == $past(instr_word[6:0]) && $stable(zero_q))
    else $error("page literal not loaded");
  AST_STORE: assert property (
    exec & is_store & (st_f > IND1_FILE) |=>
      mem_q[$past(st_f)] == $past(acc_q))
    else $error("store did not reach file register");
  AST_IND_STORE: assert property (
    exec & is_store & (st_f == IND0_FILE) |=>
      mem_q[$past(ptr0_q[DATA_AW-1:0])] == $past(acc_q))
    else $error("indirect store not redirected");
  AST_MM_PTR: assert property (
    exec & is_mm & ~sel |=> ptr0_q == ($past(mode_dec)
      ? $past(ptr0_q) - 16'h0001 : $past(ptr0_q) + 16'h0001))
    else $error("pointer auto update wrong");
  AST_WRAP: assert property (
    exec & is_mm & sel & ~mode_dec & (ptr1_q == 16'hFFFF) |=>
      ptr1_q == 16'h0000)
    else $error("pointer did not wrap");
  AST_OFS_PTR: assert property (
    exec & is_ofs |=> $stable(ptr0_q) && $stable(ptr1_q))
    else $error("offset form moved a pointer");
  AST_SEL: assert property (
    exec & is_ld & ~sel |=> $stable(ptr1_q))
    else $error("unselected pointer changed");
  // Memory indices are cut to the array's width: the pointers are wider
  // than the file, and an index past its end would read as unknown.
  AST_LD_DATA: assert property (
    exec & is_ofs & ~sel |=>
      acc_q == mem_q[$past(ptr0_q[DATA_AW-1:0] + ofs_ext[DATA_AW-1:0])]
      && zero_q == (acc_q == 8'h00))
    else $error("indirect load data or zero flag wrong");
  AST_OFS_NONE: assert property (
    exec & is_ofs & sel & (ofs == 6'h00) |=>
      acc_q == mem_q[$past(ptr1_q[DATA_AW-1:0])])
    else $error("omitted offset not taken as zero");
  AST_OFS_NEG: assert property (
    exec & is_ofs & sel & ofs[5] |=>
      acc_q == mem_q[$past(ptr1_q[DATA_AW-1:0] - DATA_AW'(7'h40 - ofs))])
    else $error("negative offset read wrong address");
  AST_MM_ZERO: assert property (
    exec & is_mm |=> zero_q == (acc_q == 8'h00))
    else $error("zero flag does not follow loaded byte");
  AST_FLAGS: assert property (
    exec & ~is_ld |=> $stable(zero_q))
    else $error("flag changed by non-load");
  AST_POST: assert property (
    exec & is_mm & mode_post & ~sel |=>
      acc_q == mem_q[$past(ptr0_q[DATA_AW-1:0])])
    else $error("post mode read wrong address");

  COV_PRE_DEC: cover property (exec & is_mm & (mode == MODE_PRE_DEC));
  COV_POST_INC: cover property (exec & is_mm & (mode == MODE_POST_INC));
  COV_NEG_OFS: cover property (exec & is_ofs & ofs[5]);
  COV_BUS_WR: cover property (wr_fire ##1 exec);

endmodule // mie_core

// ===== verif/mie_prog_mem.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// Program memory model
// ------------------------------------------------------------------------
module mie_prog_mem
  import mie_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   slow,
  output logic                        instr_valid,
  input  wire logic                   instr_ready,
  output logic [mie_pkg::INSTR_W-1:0] instr_word
);
  logic [INSTR_W-1:0] pend[$];

  task automatic push(input logic [INSTR_W-1:0] w);
    pend.push_back(w);
  endtask

  initial begin
    instr_valid = 1'b0;
    instr_word  = '0;
  end

  // Between words the bus flips every idle cycle, starting with the inverse of the last word, so a stale
  // word can never be mistaken for a fresh one.
  always @(posedge aclk) begin
    if (!aresetn) begin
      instr_valid <= 1'b0;
    end else if (!instr_valid || instr_ready) begin
      if (pend.size() != 0 && !(slow && $urandom_range(0, 2) == 0)) begin
        instr_valid <= 1'b1;
        instr_word  <= pend.pop_front();
      end else begin
        instr_valid <= 1'b0;
        instr_word  <= ~instr_word;
      end
    end
  end
endmodule // mie_prog_mem

// ===== verif/move_instruction_execution_test.sv
`timescale 1ns/10ps
module move_instruction_execution_test;
  import mie_pkg::*;
  logic        aclk, aresetn, slow, instr_valid, instr_ready;
  logic [13:0] instr_word, opc[6], msk[6];
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt, check_count, m_acc, m_zero, m_bank, m_page;
  int          m_ptr[2], m_mem[256], m_cnt;

  mie_core     i_dut (.*);
  mie_prog_mem i_pm (.*);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang;
    chk(32'h0, 32'h1);
    tally_and_finish();
  endtask

  // Readies are looked at on the falling edge, where they are settled.
  task automatic axi_wr(input logic [7:0] a, input int d, input int er);
    int n;
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b_t = 1'b0;
    for (n = 0; n < 50 && !b_t; n++) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    if (!b_t) hang();
    chk({30'h0, r}, er);
  endtask

  task automatic rchk(input logic [7:0] a, input int exp, input int er);
    int n;
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    r_t = 1'b0;
    for (n = 0; n < 50 && !r_t; n++) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    if (!r_t) hang();
    chk(d, exp);
    chk({30'h0, r}, er);
  endtask

  task automatic cmp_regs;
    rchk(REG_ACC, m_acc, RESP_OKAY);
    rchk(REG_STATUS, m_zero, RESP_OKAY);
    rchk(REG_BANK, m_bank, RESP_OKAY);
    rchk(REG_PAGE, m_page, RESP_OKAY);
    rchk(REG_PTR0, m_ptr[0], RESP_OKAY);
    rchk(REG_PTR1, m_ptr[1], RESP_OKAY);
    rchk(REG_COUNT, m_cnt, RESP_OKAY);
  endtask

  task automatic wait_idle;
    int n;
    for (n = 0; n < 5000; n++) begin
      @(negedge aclk);
      if (i_pm.pend.size() == 0 && !instr_valid) break;
    end
    @(posedge aclk);
    if (n == 5000) hang();
  endtask

  // ----------------------------------------------------------------------
  // Reference model, updated as each word is queued
  // ----------------------------------------------------------------------
  task automatic send(input logic [13:0] w);
    int n, ea, ld;
    i_pm.push(w);
    m_cnt++;
    n = w[2];
    ld = 0;
    if ((w & MSK_LIT_ACC) == OPC_LIT_ACC) m_acc = w[7:0];
    if ((w & MSK_BANK) == OPC_BANK) m_bank = w[4:0];
    if ((w & MSK_PAGE) == OPC_PAGE) m_page = w[6:0];
    if ((w & MSK_STORE) == OPC_STORE) begin
      ea = (w[6:1] == 6'h0) ? m_ptr[w[0]] : w[6:0];
      m_mem[ea & 255] = m_acc;
    end
    if ((w & MSK_IND_MM) == OPC_IND_MM) begin
      if (!w[1]) m_ptr[n] = (m_ptr[n] + (w[0] ? 65535 : 1)) & 65535;
      ea = m_ptr[n];
      if (w[1]) m_ptr[n] = (m_ptr[n] + (w[0] ? 65535 : 1)) & 65535;
      ld = 1;
    end
    if ((w & MSK_IND_OFS) == OPC_IND_OFS) begin
      ea = m_ptr[w[6]] + int'(w[5:0]) - (w[5] ? 64 : 0);
      ld = 1;
    end
    if (ld != 0) begin
      m_acc = m_mem[ea & 255];
      m_zero = (m_acc == 0);
    end
  endtask

  initial begin
    int v, k;
    aresetn = 1'b0;
    slow = 1'b0;
    s_axi_awaddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    opc = '{OPC_LIT_ACC, OPC_BANK, OPC_PAGE,
            OPC_STORE, OPC_IND_MM, OPC_IND_OFS};
    msk = '{MSK_LIT_ACC, MSK_BANK, MSK_PAGE,
            MSK_STORE, MSK_IND_MM, MSK_IND_OFS};
    void'($urandom(40));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_regs();
    rchk(8'h1C, 0, RESP_SLVERR);
    axi_wr(8'h40, 32'h5A, RESP_SLVERR);
    // Fill all memory back to back through the redirected port, wrapping.
    axi_wr(REG_PTR0, 32'h0000_FF80, RESP_OKAY);
    m_ptr[0] = 16'hFF80;
    for (int i = 0; i < 256; i++) begin
      v = (i == 255) ? 0 : $urandom_range(1, 255);
      send(OPC_LIT_ACC | 14'(v));
      send(OPC_STORE);
      send(OPC_IND_MM | {12'h0, MODE_POST_INC});
    end
    send(OPC_LIT_ACC | 14'hA5);
    send(OPC_BANK | 14'h1F);
    send(OPC_PAGE | 14'h7F);
    send(OPC_STORE | 14'h7F);
    wait_idle();
    cmp_regs();
    for (int i = 0; i < 16; i++) begin
      v = i[3] ? 32'hFFFF : 0;
      axi_wr(i[2] ? REG_PTR1 : REG_PTR0, v, RESP_OKAY);
      m_ptr[i[2]] = v;
      send(OPC_IND_MM | {11'h0, i[2:0]});
      wait_idle();
      cmp_regs();
    end
    for (int i = 0; i < 3; i++) begin
      send(OPC_IND_OFS | ((i == 0) ? 14'h20 : (i == 1) ? 14'h5F : 14'h40));
      wait_idle();
      cmp_regs();
    end
    slow <= 1'b1;
    for (int b = 0; b < 15; b++) begin
      v = $urandom_range(0, 65535);
      axi_wr(b[0] ? REG_PTR1 : REG_PTR0, v, RESP_OKAY);
      m_ptr[b[0]] = v;
      for (int j = 0; j < 20; j++) begin
        k = $urandom_range(0, 5);
        send(opc[k] | (14'($urandom) & ~msk[k]));
      end
      // A write to the read-only counter while words still stream in stalls
      // the instruction port for a cycle; no word may be lost or doubled.
      axi_wr(REG_COUNT, 32'h0000_FFFF, RESP_OKAY);
      wait_idle();
      cmp_regs();
    end
    tally_and_finish();
  end
endmodule // move_instruction_execution_test
